// ===== prl_remap_lock.sv
// remap lock, keyed unlock, input select registers and shadow check on AXI4-Lite
`timescale 1ns/1ps
module prl_remap_lock
  import prl_pkg::*;
#(
  parameter int PINS = PIN_COUNT,
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] remappable_pin_i,
  input wire logic one_way_remap_fuse_i,
  output logic quad_phase_a_o,
  output logic quad_phase_b_o,
  output logic spi2_slave_sel_o,
  output logic can_receive_o,
  output logic config_mismatch_reset_o,
  output logic irq_o
);
  initial begin
    if (PINS < 1 || PINS > 26) begin
      $error("prl_remap_lock: PINS must be 1..26");
    end
  end

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb, input logic [15:0] msk);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    merge16 = ((old & ~lanes) | (d[15:0] & lanes)) & msk;
  endfunction

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  logic aw_have_r, w_have_r, bvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  wire logic wr_fire = aw_have_r && w_have_r && !bvalid_r;

  wire logic hit_osc = (awaddr_r == OSC_CTRL_ADDR);
  wire logic hit_qei = (awaddr_r == QEI_SEL_ADDR);
  wire logic hit_spi = (awaddr_r == SPI2_SEL_ADDR);
  wire logic hit_can = (awaddr_r == CAN_SEL_ADDR) && HAS_CAN;
  wire logic hit_can_addr = (awaddr_r == CAN_SEL_ADDR);
  wire logic hit_stat = (awaddr_r == IRQ_STAT_ADDR);
  wire logic hit_mask = (awaddr_r == IRQ_MASK_ADDR);
  wire logic hit_any = hit_osc || hit_qei || hit_spi || hit_can_addr || hit_stat
                       || hit_mask || (awaddr_r == STATUS_ADDR);
  wire logic hit_remap = hit_qei || hit_spi || hit_can;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        // a blocked remap write still answers OKAY
        bresp_r <= hit_any ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // one-way fuse: synchronised, caught once after reset release
  // ----------------------------------------------------------------
  logic fuse_s1_r, fuse_s2_r, fuse_s3_r, fuse_cap_r, one_way_r;
  logic [1:0] fill_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
      fuse_s3_r <= 1'b0;
      fuse_cap_r <= 1'b0;
      fill_r <= 2'b00;
      one_way_r <= FUSE_RESET;
    end else begin
      fuse_s1_r <= one_way_remap_fuse_i;
      fuse_s2_r <= fuse_s1_r;
      fuse_s3_r <= fuse_s2_r;
      // stages hold reset zeros until the strap has walked through all three
      if (!(&fill_r)) begin
        fill_r <= fill_r + 2'b01;
      end
      // fuse is static: sample it once, later glitches cannot reopen the map
      if (!fuse_cap_r && (&fill_r) && (fuse_s2_r == fuse_s3_r)) begin
        fuse_cap_r <= 1'b1;
        one_way_r <= fuse_s3_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // keyed lock sequence
  // ----------------------------------------------------------------
  prl_key_e key_r, key_nxt;
  logic lock_r, lock_nxt;
  wire logic osc_wr = wr_fire && hit_osc && wstrb_r[0];
  wire logic [7:0] key_byte = wdata_r[7:0];
  wire logic other_wr = wr_fire && !osc_wr;
  wire logic bad_key = (osc_wr && (key_r == KEY_IDLE) && (key_byte != KEY_FIRST))
                    || (osc_wr && (key_r == KEY_ONE) && (key_byte != KEY_SECOND))
                    || (other_wr && (key_r != KEY_IDLE));

  always_comb begin
    key_nxt = key_r;
    lock_nxt = lock_r;
    if (osc_wr) begin
      unique case (key_r)
        KEY_IDLE: begin
          key_nxt = (key_byte == KEY_FIRST) ? KEY_ONE : KEY_IDLE;
        end
        KEY_ONE: begin
          key_nxt = (key_byte == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
        end
        KEY_ARMED: begin
          key_nxt = KEY_IDLE;
          // a set lock under the one-way fuse only stays set
          if (!(one_way_r && lock_r)) begin
            lock_nxt = key_byte[LOCK_BIT];
          end
        end
        default: key_nxt = KEY_IDLE;
      endcase
    end else if (other_wr) begin
      key_nxt = KEY_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_r <= KEY_IDLE;
      lock_r <= LOCK_RESET;
    end else begin
      key_r <= key_nxt;
      lock_r <= lock_nxt;
    end
  end

  // ----------------------------------------------------------------
  // select registers and their shadows
  // ----------------------------------------------------------------
  logic [15:0] qei_r, spi_r, can_r, qei_sh_r, spi_sh_r, can_sh_r;
  wire logic remap_ok = !lock_r;
  wire logic [15:0] qei_nxt = merge16(qei_r, wdata_r, wstrb_r, QEI_MASK);
  wire logic [15:0] spi_nxt = merge16(spi_r, wdata_r, wstrb_r, ONE_SEL_MASK);
  wire logic [15:0] can_nxt = merge16(can_r, wdata_r, wstrb_r, ONE_SEL_MASK);
  wire logic blocked = wr_fire && hit_remap && lock_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      qei_r <= QEI_RESET;
      spi_r <= ONE_SEL_RESET;
      can_r <= ONE_SEL_RESET;
      qei_sh_r <= QEI_RESET;
      spi_sh_r <= ONE_SEL_RESET;
      can_sh_r <= ONE_SEL_RESET;
    end else if (wr_fire && remap_ok) begin
      if (hit_qei) begin
        qei_r <= qei_nxt;
        qei_sh_r <= qei_nxt;
      end
      if (hit_spi) begin
        spi_r <= spi_nxt;
        spi_sh_r <= spi_nxt;
      end
      if (hit_can) begin
        can_r <= can_nxt;
        can_sh_r <= can_nxt;
      end
    end
  end

  // only a disturbed cell can make these differ
  wire logic mismatch = (qei_r != qei_sh_r) || (spi_r != spi_sh_r)
                        || (can_r != can_sh_r);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_mismatch_reset_o <= 1'b0;
    end else if (mismatch) begin
      config_mismatch_reset_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [EV_W-1:0] stat_r, mask_r;
  logic [EV_W-1:0] ev;
  assign ev = {mismatch, bad_key, blocked};
  wire logic [EV_W-1:0] w1c = (wr_fire && hit_stat && wstrb_r[0]) ? wdata_r[EV_W-1:0] : '0;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      // a new event beats a clear in the same cycle
      stat_r <= (stat_r & ~w1c) | ev;
      if (wr_fire && hit_mask && wstrb_r[0]) begin
        mask_r <= wdata_r[EV_W-1:0];
      end
    end
  end
  assign irq_o = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  wire logic [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rmux;
  logic rhit;

  always_comb begin
    rmux = 32'h0000_0000;
    rhit = 1'b1;
    unique case (raddr)
      OSC_CTRL_ADDR: rmux[LOCK_BIT] = lock_r;
      QEI_SEL_ADDR: rmux[15:0] = qei_r;
      SPI2_SEL_ADDR: rmux[15:0] = spi_r;
      CAN_SEL_ADDR: rmux[15:0] = HAS_CAN ? can_r : 16'h0000;
      IRQ_STAT_ADDR: rmux[EV_W-1:0] = stat_r;
      IRQ_MASK_ADDR: rmux[EV_W-1:0] = mask_r;
      STATUS_ADDR: rmux[3:0] = {key_r, one_way_r, lock_r};
      default: rhit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rmux;
      rresp_r <= rhit ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser and routing
  // ----------------------------------------------------------------
  logic [PINS-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r <= '0;
    end else begin
      pin_s1_r <= remappable_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      // a bit moves only once stages two and three agree
      pin_r <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  logic [3:0] route;
  logic [3:0][SEL_W-1:0] route_sel;
  assign route_sel[0] = qei_r[PHASE_A_LSB +: SEL_W];
  assign route_sel[1] = qei_r[PHASE_B_LSB +: SEL_W];
  assign route_sel[2] = spi_r[SEL_W-1:0];
  assign route_sel[3] = HAS_CAN ? can_r[SEL_W-1:0] : SEL_GROUND;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_route
      prl_input_mux #(.PINS(PINS)) u_mux (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .sel_i(route_sel[gi]),
        .pins_i(pin_r),
        .periph_o(route[gi])
      );
    end
  endgenerate
  assign quad_phase_a_o = route[0];
  assign quad_phase_b_o = route[1];
  assign spi2_slave_sel_o = route[2];
  assign can_receive_o = route[3];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_first_key;
    osc_wr && key_r == KEY_IDLE && key_byte == KEY_FIRST;
  endsequence
  sequence s_second_key;
    osc_wr && key_r == KEY_ONE && key_byte == KEY_SECOND;
  endsequence

  property p_locked_write;
    @(posedge clk_i) disable iff (!resetn_i)
      (wr_fire && hit_qei && lock_r) |=> (qei_r == $past(qei_r)) && s_axi_bvalid;
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed reg");

  property p_lock_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      !(osc_wr && key_r == KEY_ARMED) |=> (lock_r == $past(lock_r));
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock changed without key");

  property p_key_arms;
    @(posedge clk_i) disable iff (!resetn_i)
      s_first_key ##[1:20] s_second_key |=> key_r == KEY_ARMED;
  endproperty
  a_key_arms: assert property (p_key_arms) else $error("key sequence did not arm");

  property p_armed_sets;
    @(posedge clk_i) disable iff (!resetn_i)
      (osc_wr && key_r == KEY_ARMED && !(one_way_r && lock_r))
        |=> lock_r == $past(key_byte[LOCK_BIT]) && key_r == KEY_IDLE;
  endproperty
  a_armed_sets: assert property (p_armed_sets) else $error("armed write ignored");

  property p_one_way;
    @(posedge clk_i) disable iff (!resetn_i)
      (one_way_r && lock_r) |=> lock_r;
  endproperty
  a_one_way: assert property (p_one_way) else $error("one-way lock cleared");

  property p_bad_key;
    @(posedge clk_i) disable iff (!resetn_i)
      (osc_wr && key_r == KEY_ONE && key_byte != KEY_SECOND)
        |=> key_r == KEY_IDLE && lock_r == $past(lock_r) && stat_r[EV_BAD_KEY];
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key not rejected");

  property p_mismatch;
    @(posedge clk_i) disable iff (!resetn_i)
      mismatch |=> config_mismatch_reset_o && stat_r[EV_MISMATCH];
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not reported");

  property p_ground;
    @(posedge clk_i) disable iff (!resetn_i)
      (route_sel[2] == SEL_GROUND)[*2] |-> !spi2_slave_sel_o;
  endproperty
  a_ground: assert property (p_ground) else $error("grounded input high");

  property p_zero_upper;
    @(posedge clk_i) disable iff (!resetn_i)
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && qei_r[15:13] == 3'b000;
  endproperty
  a_zero_upper: assert property (p_zero_upper) else $error("unimplemented bits set");
endmodule

// ===== prl_pkg.sv
// package: register map, field layout and reset values of the pin remap lock block
package prl_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] QEI_SEL_ADDR = 8'h04;
  localparam logic [7:0] SPI2_SEL_ADDR = 8'h08;
  localparam logic [7:0] CAN_SEL_ADDR = 8'h0c;
  localparam logic [7:0] IRQ_STAT_ADDR = 8'h10;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h18;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int LOCK_BIT = 6;
  localparam logic [7:0] KEY_FIRST = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  localparam int SEL_W = 5;
  localparam int PHASE_A_LSB = 0;
  localparam int PHASE_B_LSB = 8;
  localparam logic [15:0] QEI_MASK = 16'h1f1f;
  localparam logic [15:0] ONE_SEL_MASK = 16'h001f;
  localparam logic [4:0] SEL_GROUND = 5'h1f;
  localparam logic [4:0] SEL_LAST_PIN = 5'h19;
  localparam int PIN_COUNT = 26;
  // status bits: 0 write blocked, 1 bad key, 2 shadow mismatch
  localparam int EV_BLOCKED = 0;
  localparam int EV_BAD_KEY = 1;
  localparam int EV_MISMATCH = 2;
  localparam int EV_W = 3;
  // status register: 0 lock, 1 one-way fuse, 2..3 key state
  localparam int ST_FUSE = 1;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] QEI_RESET = 16'h1f1f;
  localparam logic [15:0] ONE_SEL_RESET = 16'h001f;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic FUSE_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_ARMED} prl_key_e;
endpackage

// ===== prl_input_mux.sv
// one peripheral input selected from the remappable pins
`timescale 1ns/1ps
module prl_input_mux
  import prl_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic [PINS-1:0] pins_i,
  output logic periph_o
);
  initial begin
    if (PINS < 1 || PINS > 31) begin
      $error("prl_input_mux: PINS out of range");
    end
  end

  // codes past the last pin, and the all-ones code, tie the input low
  wire logic in_range = (32'(sel_i) < PINS);
  wire logic picked = in_range ? pins_i[sel_i] : 1'b0;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      periph_o <= 1'b0;
    end else begin
      periph_o <= picked;
    end
  end
endmodule

// ===== prl_pin_model.sv
// partner model: remappable pin drivers seen by the input select muxes
`timescale 1ns/1ps
module prl_pin_model
  import prl_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic [4:0] hot_i,
  input wire logic invert_i,
  output logic [PINS-1:0] pins_o
);
  // one marked pin against all others while hot_i is below PINS, so a wrong select never matches by luck
  assign pins_o = {PINS{invert_i}} ^ (PINS'(1) << hot_i);
endmodule

// ===== tb_pin_remap_lock_and_input_select.sv
// testbench: register bus, lock sequence, routing and interrupt checks
`timescale 1ns/1ps
module tb_pin_remap_lock_and_input_select
  import prl_pkg::*;
;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic fuse = 1'b0;
  logic invert = 1'b0;
  logic [4:0] hot = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, qa, qb, ss, crx, cmr, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_v;
  logic [1:0] resp_v;
  logic [PIN_COUNT-1:0] pins;
  int n_errors = 0;
  int tests_run = 0;

  always #20 clk_i = ~clk_i;

  prl_pin_model #(.PINS(PIN_COUNT)) prl_pin_model_inst (.hot_i(hot), .invert_i(invert),
    .pins_o(pins));

  prl_remap_lock #(.PINS(PIN_COUNT), .HAS_CAN(1'b1)) prl_remap_lock_inst (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .remappable_pin_i(pins), .one_way_remap_fuse_i(fuse),
    .quad_phase_a_o(qa), .quad_phase_b_o(qb), .spi2_slave_sel_o(ss), .can_receive_o(crx),
    .config_mismatch_reset_o(cmr), .irq_o(irq));

  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // handshakes judged at the falling edge, released after the taking rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    r = 2'b01;
    @(posedge clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) r = bresp;
      @(posedge clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end
    if (!tb) check("write answer", 32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tr;
    n = 0;
    tr = 1'b0;
    d = 32'h0;
    r = 2'b01;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr && n < 100) begin
      @(negedge clk_i);
      ta = arvalid && arready;
      tr = rvalid && rready;
      if (tr) d = rdata;
      if (tr) r = rresp;
      @(posedge clk_i);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end
    if (!tr) check("read answer", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp_v);
    check("write response", 32'(resp_v), 32'(RESP_OKAY));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd_v, resp_v);
    check($sformatf("register %h", a), rd_v, exp);
    check("read response", 32'(resp_v), 32'(RESP_OKAY));
  endtask

  task automatic set_lock(input logic v);
    wr(OSC_CTRL_ADDR, 32'(KEY_FIRST));
    wr(OSC_CTRL_ADDR, 32'(KEY_SECOND));
    wr(OSC_CTRL_ADDR, 32'(v) << LOCK_BIT);
  endtask

  // pin path is 5 edges; 8 leaves margin
  task automatic settle();
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic irq_chk(input logic [31:0] exp);
    @(negedge clk_i);
    check("interrupt", 32'(irq), exp);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rdc(QEI_SEL_ADDR, 32'(QEI_RESET));
    rdc(SPI2_SEL_ADDR, 32'(ONE_SEL_RESET));
    rdc(CAN_SEL_ADDR, 32'(ONE_SEL_RESET));
    rdc(OSC_CTRL_ADDR, 32'h0);
    rdc(STATUS_ADDR, 32'h0);
    invert <= 1'b1;
    settle();
    check("grounded inputs", {28'h0, qa, qb, ss, crx}, 32'h0);
  endtask

  task automatic t_routing();
    logic [4:0] codes [6];
    logic [4:0] c, c2;
    codes = '{5'h00, 5'h01, 5'h0c, 5'h19, 5'h1a, 5'h1f};
    foreach (codes[i]) begin
      c = codes[i];
      c2 = c ^ 5'h01;
      wr(QEI_SEL_ADDR, 32'hffffe0e0 | {19'h0, c2, 3'h0, c});
      rdc(QEI_SEL_ADDR, {19'h0, c2, 3'h0, c});
      wr(SPI2_SEL_ADDR, 32'hffffffe0 | {27'h0, c});
      rdc(SPI2_SEL_ADDR, {27'h0, c});
      wr(CAN_SEL_ADDR, 32'hffffffe0 | {27'h0, c2});
      rdc(CAN_SEL_ADDR, {27'h0, c2});
      hot <= c;
      invert <= 1'b0;
      settle();
      check("marked pin", {28'h0, qa, qb, ss, crx}, {28'h0, c < 5'h1a, 1'b0, c < 5'h1a, 1'b0});
      @(posedge clk_i);
      invert <= 1'b1;
      settle();
      check("other pins", {28'h0, qa, qb, ss, crx}, {28'h0, 1'b0, c2 < 5'h1a, 1'b0, c2 < 5'h1a});
    end
  endtask

  task automatic t_lock();
    wr(IRQ_MASK_ADDR, 32'h7);
    wr(IRQ_STAT_ADDR, 32'h7);
    set_lock(1'b1);
    rdc(OSC_CTRL_ADDR, 32'h40);
    wr(QEI_SEL_ADDR, 32'h0505);
    rdc(QEI_SEL_ADDR, 32'h1e1f);
    rdc(IRQ_STAT_ADDR, 32'h1);
    irq_chk(32'h1);
    wr(IRQ_MASK_ADDR, 32'h6);
    irq_chk(32'h0);
    wr(IRQ_MASK_ADDR, 32'h1);
    irq_chk(32'h1);
    wr(IRQ_STAT_ADDR, 32'h1);
    irq_chk(32'h0);
    rdc(IRQ_STAT_ADDR, 32'h0);
    set_lock(1'b0);
    rdc(OSC_CTRL_ADDR, 32'h0);
    wr(QEI_SEL_ADDR, 32'h0102);
    wr(SPI2_SEL_ADDR, 32'h0003);
    rdc(QEI_SEL_ADDR, 32'h0102);
    rdc(SPI2_SEL_ADDR, 32'h0003);
  endtask

  task automatic t_bad_key();
    wr(OSC_CTRL_ADDR, 32'h46);
    rdc(STATUS_ADDR, 32'h4);
    wr(OSC_CTRL_ADDR, 32'h58);
    rdc(STATUS_ADDR, 32'h0);
    wr(OSC_CTRL_ADDR, 32'h40);
    rdc(OSC_CTRL_ADDR, 32'h0);
    wr(OSC_CTRL_ADDR, 32'h57);
    wr(OSC_CTRL_ADDR, 32'h46);
    wr(OSC_CTRL_ADDR, 32'h40);
    rdc(OSC_CTRL_ADDR, 32'h0);
    wr(OSC_CTRL_ADDR, 32'h46);
    wr(OSC_CTRL_ADDR, 32'h57);
    wr(SPI2_SEL_ADDR, 32'h0004);
    wr(OSC_CTRL_ADDR, 32'h40);
    rdc(OSC_CTRL_ADDR, 32'h0);
    rdc(IRQ_STAT_ADDR, 32'h2);
    wr(IRQ_STAT_ADDR, 32'h2);
    set_lock(1'b1);
    rdc(OSC_CTRL_ADDR, 32'h40);
    set_lock(1'b0);
    rdc(OSC_CTRL_ADDR, 32'h0);
  endtask

  task automatic t_bus_errors();
    axi_wr(8'h1c, 32'hffffffff, resp_v);
    check("unmapped write", 32'(resp_v), 32'(RESP_DECERR));
    axi_rd(8'h1c, rd_v, resp_v);
    check("unmapped read", 32'(resp_v), 32'(RESP_DECERR));
    wr(STATUS_ADDR, 32'hffffffff);
    rdc(STATUS_ADDR, 32'h0);
  endtask

  task automatic t_one_way();
    fuse <= 1'b1;
    do_reset();
    rdc(STATUS_ADDR, 32'h2);
    rdc(QEI_SEL_ADDR, 32'(QEI_RESET));
    set_lock(1'b1);
    set_lock(1'b0);
    rdc(OSC_CTRL_ADDR, 32'h40);
    wr(QEI_SEL_ADDR, 32'h0303);
    rdc(QEI_SEL_ADDR, 32'(QEI_RESET));
    do_reset();
    rdc(OSC_CTRL_ADDR, 32'h0);
    fuse <= 1'b0;
  endtask

  initial begin
    do_reset();
    t_reset_values();
    t_routing();
    t_lock();
    t_bad_key();
    t_bus_errors();
    t_one_way();
    check("mismatch reset", 32'(cmr), 32'h0);
    complete_run();
  end

  // run needs under a thousand cycles
  initial begin
    repeat (50000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end
endmodule
